//--- verilog/alm_flag_regs.sv
// per-channel alarm flag registers read over the serial register port
//
// Functional notes
// - each channel keeps low and high thresholds, each with active and tripped flag
// - active flag follows the alarm condition, set while present, clear when gone
// - tripped flag sets like active, stays latched until its register is read
// - all eight channels' flags live at program addresses 11h to 14h
// - 11h holds channel 0-3 tripped flags, bit 7 ch0 low down to ch3 high
// - 12h holds channel 0-3 active flags with the same layout
// - 13h holds channel 4-7 tripped flags, bit 7 ch4 low down to ch7 high
// - a flag bit reads 1 for alarm detected, 0 for none
// - all flag bits are read-only and reset to zero
// - four-channel build: writes to 13h are ignored with no effect
// - four-channel build: reading 13h shifts out all ones
// - 14h holds channel 4-7 active flags, absent in four-channel build
// - 10h gives per channel OR of its low and high tripped flags; bits of absent channels read as one
module alm_flag_regs #(
	parameter int NUM_CHAN = 8
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] low_alarm_event,
	input  wire logic [7:0] high_alarm_event,
	input  wire logic       serial_clock,
	input  wire logic       serial_select_n,
	input  wire logic       serial_data_input,
	output logic            serial_data_output
);

	typedef struct packed {
		logic        dout_bit;
		logic        sclk_prev;
		logic [4:0]  bit_cnt;
		logic [15:0] shift_in;
		logic [7:0]  shift_out;
		logic [15:0] live;
		logic [15:0] latched;
	} alm_state_t;

	alm_state_t  s_q;
	alm_state_t  s_d;

	logic [2:0]  pins_raw;
	logic [2:0]  pins;
	logic [15:0] event_vec;
	logic [7:0]  overview;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [15:0] cmd_word;
	logic [6:0]  cmd_addr;
	logic        cmd_write;
	logic [7:0]  read_data;
	logic [15:0] clear_mask;

	localparam bit HAS_HIGH = (NUM_CHAN > alm_pkg::CHAN_PER_BYTE);

	assign pins_raw = {serial_data_input, serial_select_n, serial_clock};

	alm_pin_sync #(
		.W        (3),
		.IDLE_VAL (alm_pkg::PIN_IDLE)
	) u_pin_sync (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.pin_raw   (pins_raw),
		.pin_clean (pins)
	);

	// pack the comparator events into register bit order; absent channels stay low
	genvar c;
	generate
		for (c = 0; c < 8; c++)
		begin : g_chan
			localparam int BYTE = c / alm_pkg::CHAN_PER_BYTE;
			localparam int SLOT = c % alm_pkg::CHAN_PER_BYTE;
			localparam int LO   = 8 * BYTE + alm_pkg::FLAG_LOW_TOP - 2 * SLOT;
			localparam int HI   = 8 * BYTE + alm_pkg::FLAG_HIGH_TOP - 2 * SLOT;
			if (c < NUM_CHAN)
			begin : g_present
				assign event_vec[LO] = low_alarm_event[c];
				assign event_vec[HI] = high_alarm_event[c];
				assign overview[c]   = s_q.latched[LO] | s_q.latched[HI];
			end
			else
			begin : g_absent
				assign event_vec[LO] = 1'b0;
				assign event_vec[HI] = 1'b0;
				// overview bits of a missing channel read as one
				assign overview[c]   = 1'b1;
			end
		end
	endgenerate

	assign sclk_rise = pins[alm_pkg::PIN_SCLK] & ~s_q.sclk_prev;
	assign sclk_fall = ~pins[alm_pkg::PIN_SCLK] & s_q.sclk_prev;

	// the 16th bit is still in flight, so decode the word it will complete
	assign cmd_word  = {s_q.shift_in[14:0], pins[alm_pkg::PIN_SDI]};
	assign cmd_addr  = cmd_word[alm_pkg::CMD_ADDR_MSB:alm_pkg::CMD_ADDR_LSB];
	assign cmd_write = cmd_word[alm_pkg::CMD_WRITE_BIT];

	always_comb
	begin
		read_data  = alm_pkg::UNMAPPED_READ;
		clear_mask = '0;
		unique case (cmd_addr)
			alm_pkg::ADDR_OVERVIEW:
			begin
				read_data = overview;
			end
			alm_pkg::ADDR_LOW_LATCHED:
			begin
				read_data  = s_q.latched[7:0];
				clear_mask = 16'h00ff;
			end
			alm_pkg::ADDR_LOW_LIVE:
			begin
				read_data = s_q.live[7:0];
			end
			alm_pkg::ADDR_HIGH_LATCHED:
			begin
				if (HAS_HIGH)
				begin
					read_data  = s_q.latched[15:8];
					clear_mask = 16'hff00;
				end
				else
				begin
					read_data = alm_pkg::ABSENT_READ;
				end
			end
			alm_pkg::ADDR_HIGH_LIVE:
			begin
				if (HAS_HIGH)
				begin
					read_data = s_q.live[15:8];
				end
				else
				begin
					read_data = alm_pkg::ABSENT_READ;
				end
			end
			default:
			begin
				read_data = alm_pkg::UNMAPPED_READ;
			end
		endcase
	end

	always_comb
	begin
		s_d           = s_q;
		s_d.sclk_prev = pins[alm_pkg::PIN_SCLK];
		// active flags mirror the condition, one cycle behind the comparator
		s_d.live      = event_vec;
		// set after clear, so an event in the clearing cycle survives
		s_d.latched   = s_q.latched | event_vec;

		if (pins[alm_pkg::PIN_CS_N])
		begin
			s_d.bit_cnt   = '0;
			s_d.shift_out = '0;
			s_d.dout_bit  = 1'b0;
		end
		else
		begin
			if (sclk_rise && (s_q.bit_cnt != alm_pkg::FRAME_BITS))
			begin
				s_d.shift_in = cmd_word;
				s_d.bit_cnt  = s_q.bit_cnt + 5'h01;
				if (s_q.bit_cnt == alm_pkg::FRAME_CMD_BITS - 5'h01)
				begin
					// writes find nothing writable here and change no state
					if (!cmd_write)
					begin
						s_d.shift_out = read_data;
						s_d.latched   = (s_q.latched & ~clear_mask) | event_vec;
					end
					else
					begin
						s_d.shift_out = '0;
					end
				end
			end
			if (sclk_fall)
			begin
				if ((s_q.bit_cnt >= alm_pkg::FRAME_CMD_BITS) &&
					(s_q.bit_cnt < alm_pkg::FRAME_BITS))
				begin
					s_d.dout_bit  = s_q.shift_out[7];
					s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
				end
				else
				begin
					s_d.dout_bit = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			s_q           <= '0;
			s_q.live      <= {alm_pkg::FLAG_RESET, alm_pkg::FLAG_RESET};
			s_q.latched   <= {alm_pkg::FLAG_RESET, alm_pkg::FLAG_RESET};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign serial_data_output = s_q.dout_bit;

endmodule

//--- verilog/alm_pkg.sv
// constants for the channel alarm flag register block
package alm_pkg;

	// register addresses within the program register space
	localparam logic [6:0] ADDR_OVERVIEW      = 7'h10;
	localparam logic [6:0] ADDR_LOW_LATCHED   = 7'h11;
	localparam logic [6:0] ADDR_LOW_LIVE      = 7'h12;
	localparam logic [6:0] ADDR_HIGH_LATCHED  = 7'h13;
	localparam logic [6:0] ADDR_HIGH_LIVE     = 7'h14;

	// reset value of every flag register and the answer of an absent register
	localparam logic [7:0] FLAG_RESET         = 8'h00;
	localparam logic [7:0] ABSENT_READ        = 8'hff;
	localparam logic [7:0] UNMAPPED_READ      = 8'h00;

	// serial frame: 7-bit address, write bit, 8 ignored bits, then 8 data bit times
	localparam logic [4:0] FRAME_CMD_BITS     = 5'h10;
	localparam logic [4:0] FRAME_BITS         = 5'h18;
	localparam int         CMD_ADDR_MSB       = 15;
	localparam int         CMD_ADDR_LSB       = 9;
	localparam int         CMD_WRITE_BIT      = 8;

	// flag layout inside one byte: channel slot k, low at 7-2k, high at 6-2k
	localparam int         FLAG_LOW_TOP       = 7;
	localparam int         FLAG_HIGH_TOP      = 6;
	localparam int         CHAN_PER_BYTE      = 4;

	// pin synchroniser reset levels: sclk, cs_n, sdi
	localparam logic [2:0] PIN_IDLE           = 3'h2;
	localparam int         PIN_SCLK           = 0;
	localparam int         PIN_CS_N           = 1;
	localparam int         PIN_SDI            = 2;

endpackage

//--- verilog/alm_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module alm_pin_sync #(
	parameter int          W        = 3,
	parameter logic [W-1:0] IDLE_VAL = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_raw,
	output logic      [W-1:0] pin_clean
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] clean;
	} alm_sync_state_t;

	alm_sync_state_t s_q;
	alm_sync_state_t s_d;

	// stage one feeds only stage two; the filter looks at stages two and three
	always_comb
	begin
		s_d    = s_q;
		s_d.s1 = pin_raw;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < W; i++)
		begin
			if (s_q.s2[i] == s_q.s3[i])
			begin
				s_d.clean[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			s_q <= {IDLE_VAL, IDLE_VAL, IDLE_VAL, IDLE_VAL};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign pin_clean = s_q.clean;

endmodule

//--- verif/alm_flag_chk.sv
// port-level assertions for the alarm flag register block
module alm_flag_chk (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] low_alarm_event,
	input wire logic [7:0] high_alarm_event,
	input wire logic       serial_clock,
	input wire logic       serial_select_n,
	input wire logic       serial_data_input,
	input wire logic       serial_data_output
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_rst; $fell(sys_rst) |-> !serial_data_output; endproperty
	a_rst: assert property (p_rst) else $error("output high at reset exit");
	property p_wake; $fell(sys_rst) |=> !serial_data_output [*3]; endproperty
	a_wake: assert property (p_wake) else $error("output high after reset");
	property p_idle; serial_select_n [*8] |-> !serial_data_output; endproperty
	a_idle: assert property (p_idle) else $error("output high while deselected");
	property p_out; serial_data_output |-> !$past(serial_select_n, 6); endproperty
	a_out: assert property (p_out) else $error("output high outside a frame");
	property p_chg; $changed(serial_data_output) |-> !serial_clock; endproperty
	a_chg: assert property (p_chg) else $error("output moved with clock high");
	property p_hold; $rose(serial_clock) |=> $stable(serial_data_output) [*6]; endproperty
	a_hold: assert property (p_hold) else $error("output not held after rise");
	property p_cmd; $fell(serial_select_n) |-> !serial_data_output [*8]; endproperty
	a_cmd: assert property (p_cmd) else $error("output high in command");
	property p_evt; ($changed(low_alarm_event) || $changed(high_alarm_event))
		&& $past(serial_select_n) |=> !serial_data_output [*8]; endproperty
	a_evt: assert property (p_evt) else $error("event reached the output");
endmodule

bind alm_flag_regs alm_flag_chk chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.low_alarm_event(low_alarm_event), .high_alarm_event(high_alarm_event),
	.serial_clock(serial_clock), .serial_select_n(serial_select_n),
	.serial_data_input(serial_data_input), .serial_data_output(serial_data_output));

//--- verif/alm_host_model.sv
// serial host that frames register reads and writes
module alm_host_model (
	input  wire logic ref_clk,
	output logic      serial_clock,
	output logic      serial_select_n,
	output logic      serial_data_input,
	input  wire logic serial_data_output
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		serial_clock = 1'b0;
		serial_select_n = 1'b1;
		serial_data_input = 1'b0;
	end
	task automatic half();
		repeat (8) @(negedge ref_clk);
	endtask
	// drive on fall, sample on rise; clock stands still between frames
	task automatic xfer(input logic [6:0] addr, input logic wr, output logic [7:0] rd);
		logic [23:0] frame;
		// 16-bit command (address, write bit, discarded data) then 8 read bit times
		frame = {addr, wr, 8'ha5, 8'h00};
		serial_select_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			serial_data_input = frame[i];
			half();
			serial_clock = 1'b1;
			if (i < 8)
				rd[i] = serial_data_output;
			half();
			serial_clock = 1'b0;
		end
		serial_select_n = 1'b1;
		// released line must not keep the last bit
		serial_data_input = ~serial_data_input;
		half();
	endtask
endmodule

//--- verif/testbench.sv
// testbench for the alarm flag registers, eight and four channel builds
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk;
	logic       sys_rst;
	logic [7:0] low_alarm_event;
	logic [7:0] high_alarm_event;
	logic       serial_clock;
	logic       serial_select_n;
	logic       serial_data_input;
	logic       out8;
	logic       out4;
	logic       sel4;
	int         fail_count;
	int         n_checks;
	wire logic  mux_out = sel4 ? out4 : out8;
	alm_flag_regs #(.NUM_CHAN(8)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.low_alarm_event(low_alarm_event), .high_alarm_event(high_alarm_event),
		.serial_clock(serial_clock), .serial_select_n(serial_select_n),
		.serial_data_input(serial_data_input), .serial_data_output(out8));
	alm_flag_regs #(.NUM_CHAN(4)) dut4_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.low_alarm_event(low_alarm_event), .high_alarm_event(high_alarm_event),
		.serial_clock(serial_clock), .serial_select_n(serial_select_n),
		.serial_data_input(serial_data_input), .serial_data_output(out4));
	alm_host_model host_u (.ref_clk(ref_clk), .serial_clock(serial_clock),
		.serial_select_n(serial_select_n), .serial_data_input(serial_data_input),
		.serial_data_output(mux_out));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// optional write first, then read back and compare
	task automatic chk(input logic [6:0] a, input logic [7:0] exp, input logic wr = 1'b0);
		logic [7:0] got;
		if (wr)
			host_u.xfer(a, 1'b1, got);
		host_u.xfer(a, 1'b0, got);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: addr %h got %h exp %h", $time, a, got, exp);
		end
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial
	begin
		#200000;
		fail_count++;
		stop_test();
	end
	initial
	begin
		fail_count = 0;
		n_checks = 0;
		sel4 = 1'b0;
		sys_rst = 1'b1;
		low_alarm_event = 8'h00;
		high_alarm_event = 8'h00;
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		for (int a = 16; a <= 21; a++)
			chk(a[6:0], 8'h00);
		chk(7'h12, 8'h00, 1'b1);
		$display("test reset done");
		low_alarm_event = 8'h21;
		high_alarm_event = 8'h08;
		chk(7'h10, 8'h29);
		chk(7'h12, 8'h81);
		chk(7'h14, 8'h20);
		chk(7'h11, 8'h81);
		low_alarm_event = 8'h00;
		high_alarm_event = 8'h00;
		chk(7'h12, 8'h00);
		chk(7'h10, 8'h29);
		chk(7'h11, 8'h81);
		chk(7'h11, 8'h00);
		chk(7'h13, 8'h20);
		chk(7'h13, 8'h00);
		chk(7'h10, 8'h00);
		$display("test flags done");
		sel4 = 1'b1;
		chk(7'h13, 8'hff);
		chk(7'h13, 8'hff, 1'b1);
		chk(7'h14, 8'hff);
		chk(7'h10, 8'hf0);
		low_alarm_event = 8'h21;
		high_alarm_event = 8'h08;
		chk(7'h12, 8'h81);
		chk(7'h10, 8'hf9);
		low_alarm_event = 8'h00;
		high_alarm_event = 8'h00;
		// mid-run reset must drop the latched flags still held
		sys_rst = 1'b1;
		repeat (4) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(7'h11, 8'h00);
		chk(7'h10, 8'hf0);
		$display("test four channel done");
		stop_test();
	end
endmodule
